// ==== include/i2cm_pkg.sv ====
// constants, field positions and state type of the i2c master block
package i2cm_pkg;
    localparam logic [31:0] MASTER_BASE = 32'h4002_0000;
    localparam logic [31:0] SLAVE_BASE = 32'h4002_0800;
    localparam int BASE_LSB = 11;
    localparam logic [10:0] OFF_TARGET_ADDRESS = 11'h000;
    localparam logic [10:0] OFF_COMMAND_AND_STATE = 11'h004;
    localparam logic [10:0] OFF_TRANSFER_BYTE = 11'h008;
    localparam logic [10:0] OFF_SCL_DIVIDER = 11'h00C;
    localparam logic [10:0] OFF_IRQ_ENABLE_MASK = 11'h010;
    localparam logic [10:0] OFF_IRQ_RAW_FLAGS = 11'h014;
    localparam logic [10:0] OFF_IRQ_MASKED_FLAGS = 11'h018;
    localparam logic [10:0] OFF_IRQ_CLEAR = 11'h01C;
    localparam logic [10:0] OFF_FUNCTION_CONFIG = 11'h020;
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    localparam logic [31:0] RST_SCL_DIVIDER = 32'h0000_0001;
    localparam int ADDR_DIR_BIT = 0;
    localparam int STAT_BUSY = 0;
    localparam int STAT_ERROR = 1;
    localparam int STAT_ADDRESS_NACK = 2;
    localparam int STAT_DATA_NACK = 3;
    localparam int STAT_ARBITRATION_LOST = 4;
    localparam int STAT_IDLE = 5;
    localparam int STAT_BUS_OCCUPIED = 6;
    localparam int CMD_RUN = 0;
    localparam int CMD_START = 1;
    localparam int CMD_STOP = 2;
    localparam int CMD_ACK = 3;
    localparam int CFG_MASTER_EN = 5;
    localparam int IRQ_DONE_BIT = 0;
    localparam logic [3:0] LOW_PHASE_COUNT = 4'h6;
    localparam logic [3:0] HIGH_PHASE_COUNT = 4'h4;
    localparam logic [3:0] PHASES_PER_BIT = LOW_PHASE_COUNT + HIGH_PHASE_COUNT;
    localparam logic [3:0] PH_LAST = PHASES_PER_BIT - 4'h1;
    localparam logic [3:0] PH_SDA_CHANGE = 4'h1;
    localparam logic [3:0] PH_SAMPLE = 4'h8;
    localparam logic [3:0] PH_START_SCL_REL = 4'h3;
    localparam logic [3:0] PH_START_SDA_LOW = 4'h7;
    localparam logic [3:0] PH_STOP_SDA_REL = 4'h8;
    localparam logic [3:0] ACK_BIT_INDEX = 4'h8;
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_START = 5'b00010,
        ST_SHIFT = 5'b00100,
        ST_STOP = 5'b01000,
        ST_HOLD = 5'b10000
    } i2cm_state_t;
endpackage : i2cm_pkg

// ==== design/i2cm_tick.sv ====
// phase tick divider: one pulse every 2*(divider+1) clocks while running
`timescale 1ns/1ps
module i2cm_tick #(
    parameter int DIV_W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [DIV_W-1:0] divider,
    input wire logic run,
    output logic tick
);
    logic [DIV_W:0] cntQ;
    logic [DIV_W:0] cntD;
    logic [DIV_W:0] limit;
    logic tickQ;
    logic tickD;

    // ten phases per scl period, so a phase is 2*(divider+1) clocks
    assign limit = {divider, 1'b1};

    always_comb begin
        cntD = cntQ + {{DIV_W{1'b0}}, 1'b1};
        tickD = 1'b0;
        if (!run) begin
            cntD = '0;
        end else if (cntQ >= limit) begin
            cntD = '0;
            tickD = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cntQ <= '0;
            tickQ <= 1'b0;
        end else begin
            cntQ <= cntD;
            tickQ <= tickD;
        end
    end

    assign tick = tickQ;

    a_tick_spacing: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(run) |-> !tick [*2])
        else $error("phase tick came too soon after start");
endmodule : i2cm_tick

// ==== design/i2cm_line_mon.sv ====
// line synchronisers and start/stop watcher for the shared bus
`timescale 1ns/1ps
module i2cm_line_mon (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sclSync,
    output logic sdaSync,
    output logic busOccupied
);
    logic [1:0] metaQ;
    logic [1:0] syncQ;
    logic [1:0] prevQ;
    logic occQ;
    logic occD;
    logic startSeen;
    logic stopSeen;

    // bit 1 scl, bit 0 sda; sda edges only count while scl stays high
    assign startSeen = syncQ[1] && prevQ[1] && prevQ[0] && !syncQ[0];
    assign stopSeen = syncQ[1] && prevQ[1] && !prevQ[0] && syncQ[0];

    always_comb begin
        occD = occQ;
        if (startSeen) begin
            occD = 1'b1;
        end else if (stopSeen) begin
            occD = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            metaQ <= 2'h3;
            syncQ <= 2'h3;
            prevQ <= 2'h3;
            occQ <= 1'b0;
        end else begin
            metaQ <= {sclIn, sdaIn};
            syncQ <= metaQ;
            prevQ <= syncQ;
            occQ <= occD;
        end
    end

    assign sclSync = syncQ[1];
    assign sdaSync = syncQ[0];
    assign busOccupied = occQ;

    a_bus_start: assert property (@(posedge clk) disable iff (!rst_n)
        startSeen |=> busOccupied)
        else $error("bus not marked busy after start");
    a_bus_stop: assert property (@(posedge clk) disable iff (!rst_n)
        stopSeen && !startSeen |=> !busOccupied)
        else $error("bus not marked free after stop");
endmodule : i2cm_line_mon

// ==== design/i2cm_master.sv ====
// apb programmed i2c bus master: register file, byte engine, interrupt
// Behaviour
// - divider = clock / (2*(6+4)*scl rate) - 1; low 6, high 4 phases.
// - divider register sets system clocks per scl period; scl timed from it.
// - writing config with master enable pattern enables and initialises master.
// - address bits 7:1 sent msb first as first seven bits after start.
// - address bit 0 picks direction: 0 send, 1 receive.
// - offset 0x004 takes four command bits on write, gives seven status bits on read.
// - start bit makes start on idle bus, repeated start when bus owned.
// - stop bit ends cycle with stop, or holds bus for burst bytes.
// - single send: address dir 0, write stop+start+run; start, address, byte, stop.
// - completion or error abort raises interrupt; received byte readable in data.
// - receive with ack bit set acks each byte; software clears for last byte.
// - master and slave decode offsets from own bases, 0x40020000 and 0x40020800; this block decodes only the master base, slave window gets pslverr.
// - status bits: busy, error, addr nack, data nack, arb lost, idle, bus busy.
// - command bits: run 0, start 1, stop 2, ack 3; bits 6:4 ignored.
// - error set on address nack, data nack or lost arbitration.
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
module i2cm_master #(
    parameter int DIV_W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic sclIn,
    output logic sclOut,
    output logic sclOe,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe
);
    i2cm_pkg::i2cm_state_t stateQ;
    i2cm_pkg::i2cm_state_t stateD;
    logic [3:0] phQ;
    logic [3:0] phD;
    logic [3:0] bitQ;
    logic [3:0] bitD;
    logic [7:0] shQ;
    logic [7:0] shD;
    logic addrPhQ;
    logic addrPhD;
    logic rxQ;
    logic rxD;
    logic stopQ;
    logic stopD;
    logic ackQ;
    logic ackD;
    logic adrNackQ;
    logic adrNackD;
    logic datNackQ;
    logic datNackD;
    logic arbQ;
    logic arbD;
    logic [7:0] dataQ;
    logic [7:0] dataD;
    logic [7:0] addrQ;
    logic [7:0] addrD;
    logic [DIV_W-1:0] divQ;
    logic [DIV_W-1:0] divD;
    logic maskQ;
    logic maskD;
    logic rawQ;
    logic rawD;
    logic enQ;
    logic enD;
    logic sclOeQ;
    logic sclOeD;
    logic sdaOeQ;
    logic sdaOeD;
    logic [31:0] rdQ;
    logic [31:0] rdD;
    logic [10:0] off;
    logic hit;
    logic mapped;
    logic wr;
    logic cmdWr;
    logic done;
    logic tick;
    logic advance;
    logic lastPh;
    logic sampleNow;
    logic txMode;
    logic sclS;
    logic sdaS;
    logic busOcc;
    logic engaged;
    logic [6:0] status;

    i2cm_tick #(.DIV_W(DIV_W)) i2cm_tick_inst (
        .clk(clk),
        .rst_n(rst_n),
        .divider(divQ),
        .run(engaged),
        .tick(tick)
    );

    i2cm_line_mon i2cm_line_mon_inst (
        .clk(clk),
        .rst_n(rst_n),
        .sclIn(sclIn),
        .sdaIn(sdaIn),
        .sclSync(sclS),
        .sdaSync(sdaS),
        .busOccupied(busOcc)
    );

    // only the master window is decoded; the slave window answers elsewhere
    assign off = paddr[10:0];
    assign hit = paddr[31:i2cm_pkg::BASE_LSB]
        == i2cm_pkg::MASTER_BASE[31:i2cm_pkg::BASE_LSB];
    always_comb begin
        case (off)
            i2cm_pkg::OFF_TARGET_ADDRESS, i2cm_pkg::OFF_COMMAND_AND_STATE,
            i2cm_pkg::OFF_TRANSFER_BYTE, i2cm_pkg::OFF_SCL_DIVIDER,
            i2cm_pkg::OFF_IRQ_ENABLE_MASK, i2cm_pkg::OFF_IRQ_RAW_FLAGS,
            i2cm_pkg::OFF_IRQ_MASKED_FLAGS, i2cm_pkg::OFF_IRQ_CLEAR,
            i2cm_pkg::OFF_FUNCTION_CONFIG: mapped = hit;
            default: mapped = 1'b0;
        endcase
    end
    assign wr = psel && penable && pwrite && mapped;
    assign cmdWr = wr && off == i2cm_pkg::OFF_COMMAND_AND_STATE;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    assign engaged = stateQ != i2cm_pkg::ST_IDLE && stateQ != i2cm_pkg::ST_HOLD;
    // a released scl still read low means a slave stretches it: freeze phase
    assign advance = tick && !(!sclOeQ && !sclS);
    assign lastPh = advance && phQ == i2cm_pkg::PH_LAST;
    assign sampleNow = advance && phQ == i2cm_pkg::PH_SAMPLE;
    assign txMode = addrPhQ || !rxQ;

    assign status[i2cm_pkg::STAT_BUSY] = engaged;
    assign status[i2cm_pkg::STAT_ERROR] = adrNackQ || datNackQ || arbQ;
    assign status[i2cm_pkg::STAT_ADDRESS_NACK] = adrNackQ;
    assign status[i2cm_pkg::STAT_DATA_NACK] = datNackQ;
    assign status[i2cm_pkg::STAT_ARBITRATION_LOST] = arbQ;
    assign status[i2cm_pkg::STAT_IDLE] = stateQ == i2cm_pkg::ST_IDLE;
    assign status[i2cm_pkg::STAT_BUS_OCCUPIED] = busOcc;

    // register file
    always_comb begin
        addrD = addrQ;
        divD = divQ;
        maskD = maskQ;
        enD = enQ;
        rawD = rawQ;
        if (wr && off == i2cm_pkg::OFF_TARGET_ADDRESS) begin
            addrD = pwdata[7:0];
        end
        if (wr && off == i2cm_pkg::OFF_SCL_DIVIDER) begin
            divD = pwdata[DIV_W-1:0];
        end
        if (wr && off == i2cm_pkg::OFF_IRQ_ENABLE_MASK) begin
            maskD = pwdata[i2cm_pkg::IRQ_DONE_BIT];
        end
        if (wr && off == i2cm_pkg::OFF_FUNCTION_CONFIG) begin
            enD = pwdata[i2cm_pkg::CFG_MASTER_EN];
        end
        if (wr && off == i2cm_pkg::OFF_IRQ_CLEAR && pwdata[i2cm_pkg::IRQ_DONE_BIT]) begin
            rawD = 1'b0;
        end
        // a completion in the clearing cycle must not be lost
        if (done) begin
            rawD = 1'b1;
        end
        rdD = 32'h0000_0000;
        case (off)
            i2cm_pkg::OFF_TARGET_ADDRESS: rdD[7:0] = addrQ;
            i2cm_pkg::OFF_COMMAND_AND_STATE: rdD[6:0] = status;
            i2cm_pkg::OFF_TRANSFER_BYTE: rdD[7:0] = dataQ;
            i2cm_pkg::OFF_SCL_DIVIDER: rdD[DIV_W-1:0] = divQ;
            i2cm_pkg::OFF_IRQ_ENABLE_MASK: rdD[i2cm_pkg::IRQ_DONE_BIT] = maskQ;
            i2cm_pkg::OFF_IRQ_RAW_FLAGS: rdD[i2cm_pkg::IRQ_DONE_BIT] = rawQ;
            i2cm_pkg::OFF_IRQ_MASKED_FLAGS: rdD[i2cm_pkg::IRQ_DONE_BIT] = rawQ && maskQ;
            i2cm_pkg::OFF_FUNCTION_CONFIG: rdD[i2cm_pkg::CFG_MASTER_EN] = enQ;
            default: rdD = 32'h0000_0000;
        endcase
        if (!mapped) begin
            rdD = 32'h0000_0000;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            addrQ <= i2cm_pkg::RST_ZERO[7:0];
            divQ <= i2cm_pkg::RST_SCL_DIVIDER[DIV_W-1:0];
            maskQ <= i2cm_pkg::RST_ZERO[0];
            enQ <= i2cm_pkg::RST_ZERO[0];
            rawQ <= i2cm_pkg::RST_ZERO[0];
            rdQ <= i2cm_pkg::RST_ZERO;
        end else begin
            addrQ <= addrD;
            divQ <= divD;
            maskQ <= maskD;
            enQ <= enD;
            rawQ <= rawD;
            if (psel && !penable) begin
                rdQ <= rdD;
            end
        end
    end

    assign prdata = rdQ;
    assign irq = rawQ && maskQ;

    // byte engine
    always_comb begin
        stateD = stateQ;
        phD = phQ;
        bitD = bitQ;
        shD = shQ;
        addrPhD = addrPhQ;
        rxD = rxQ;
        stopD = stopQ;
        ackD = ackQ;
        adrNackD = adrNackQ;
        datNackD = datNackQ;
        arbD = arbQ;
        dataD = dataQ;
        done = 1'b0;
        if (advance) begin
            phD = lastPh ? 4'h0 : phQ + 4'h1;
        end
        if (wr && off == i2cm_pkg::OFF_TRANSFER_BYTE) begin
            dataD = pwdata[7:0];
        end
        if (wr && off == i2cm_pkg::OFF_FUNCTION_CONFIG && pwdata[i2cm_pkg::CFG_MASTER_EN]) begin
            adrNackD = 1'b0;
            datNackD = 1'b0;
            arbD = 1'b0;
        end
        case (stateQ)
            i2cm_pkg::ST_IDLE: begin
                if (cmdWr && enQ && pwdata[i2cm_pkg::CMD_START] && pwdata[i2cm_pkg::CMD_RUN]) begin
                    stateD = i2cm_pkg::ST_START;
                    phD = 4'h0;
                    stopD = pwdata[i2cm_pkg::CMD_STOP];
                    ackD = pwdata[i2cm_pkg::CMD_ACK];
                    adrNackD = 1'b0;
                    datNackD = 1'b0;
                    arbD = 1'b0;
                end
            end
            i2cm_pkg::ST_HOLD: begin
                if (cmdWr && enQ) begin
                    stopD = pwdata[i2cm_pkg::CMD_STOP];
                    ackD = pwdata[i2cm_pkg::CMD_ACK];
                    phD = 4'h0;
                    if (pwdata[i2cm_pkg::CMD_START] && pwdata[i2cm_pkg::CMD_RUN]) begin
                        stateD = i2cm_pkg::ST_START;
                    end else if (pwdata[i2cm_pkg::CMD_RUN]) begin
                        stateD = i2cm_pkg::ST_SHIFT;
                        addrPhD = 1'b0;
                        bitD = 4'h0;
                        shD = rxQ ? 8'h00 : dataQ;
                    end else if (pwdata[i2cm_pkg::CMD_STOP]) begin
                        stateD = i2cm_pkg::ST_STOP;
                    end
                end
            end
            i2cm_pkg::ST_START: begin
                if (lastPh) begin
                    stateD = i2cm_pkg::ST_SHIFT;
                    addrPhD = 1'b1;
                    bitD = 4'h0;
                    shD = addrQ;
                    rxD = addrQ[i2cm_pkg::ADDR_DIR_BIT];
                end
            end
            i2cm_pkg::ST_SHIFT: begin
                if (sampleNow && bitQ != i2cm_pkg::ACK_BIT_INDEX) begin
                    if (txMode && shQ[7] && !sdaS) begin
                        // another master drove low: let go of both lines at once
                        arbD = 1'b1;
                        stateD = i2cm_pkg::ST_IDLE;
                        done = 1'b1;
                    end else if (!txMode) begin
                        shD = {shQ[6:0], sdaS};
                    end
                end else if (sampleNow && txMode && sdaS) begin
                    adrNackD = adrNackQ || addrPhQ;
                    datNackD = datNackQ || !addrPhQ;
                end
                if (lastPh) begin
                    if (bitQ != i2cm_pkg::ACK_BIT_INDEX) begin
                        bitD = bitQ + 4'h1;
                        if (txMode) begin
                            shD = {shQ[6:0], 1'b0};
                        end
                    end else if (adrNackQ || datNackQ) begin
                        stateD = i2cm_pkg::ST_STOP;
                    end else if (addrPhQ) begin
                        addrPhD = 1'b0;
                        bitD = 4'h0;
                        shD = rxQ ? 8'h00 : dataQ;
                    end else begin
                        if (rxQ) begin
                            dataD = shQ;
                        end
                        if (stopQ) begin
                            stateD = i2cm_pkg::ST_STOP;
                        end else begin
                            stateD = i2cm_pkg::ST_HOLD;
                            done = 1'b1;
                        end
                    end
                end
            end
            i2cm_pkg::ST_STOP: begin
                if (lastPh) begin
                    stateD = i2cm_pkg::ST_IDLE;
                    done = 1'b1;
                end
            end
            default: stateD = i2cm_pkg::ST_IDLE;
        endcase
    end

    // line drive; in ST_SHIFT sda only moves from phase 1 on, well inside scl low
    always_comb begin
        sclOeD = 1'b0;
        sdaOeD = sdaOeQ;
        case (stateQ)
            i2cm_pkg::ST_IDLE: sdaOeD = 1'b0;
            i2cm_pkg::ST_HOLD: sclOeD = 1'b1;
            i2cm_pkg::ST_START: begin
                sclOeD = phQ < i2cm_pkg::PH_START_SCL_REL;
                sdaOeD = phQ >= i2cm_pkg::PH_START_SDA_LOW;
            end
            i2cm_pkg::ST_SHIFT: begin
                sclOeD = phQ < i2cm_pkg::LOW_PHASE_COUNT;
                if (phQ >= i2cm_pkg::PH_SDA_CHANGE) begin
                    if (bitQ == i2cm_pkg::ACK_BIT_INDEX) begin
                        sdaOeD = !txMode && ackQ;
                    end else begin
                        sdaOeD = txMode && !shQ[7];
                    end
                end
            end
            i2cm_pkg::ST_STOP: begin
                sclOeD = phQ < i2cm_pkg::LOW_PHASE_COUNT;
                if (phQ >= i2cm_pkg::PH_SDA_CHANGE) begin
                    sdaOeD = phQ < i2cm_pkg::PH_STOP_SDA_REL;
                end
            end
            default: sdaOeD = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stateQ <= i2cm_pkg::ST_IDLE;
            phQ <= 4'h0;
            bitQ <= 4'h0;
            shQ <= 8'h00;
            addrPhQ <= 1'b0;
            rxQ <= 1'b0;
            stopQ <= 1'b0;
            ackQ <= 1'b0;
            adrNackQ <= 1'b0;
            datNackQ <= 1'b0;
            arbQ <= 1'b0;
            dataQ <= i2cm_pkg::RST_ZERO[7:0];
            sclOeQ <= 1'b0;
            sdaOeQ <= 1'b0;
        end else begin
            stateQ <= stateD;
            phQ <= phD;
            bitQ <= bitD;
            shQ <= shD;
            addrPhQ <= addrPhD;
            rxQ <= rxD;
            stopQ <= stopD;
            ackQ <= ackD;
            adrNackQ <= adrNackD;
            datNackQ <= datNackD;
            arbQ <= arbD;
            dataQ <= dataD;
            sclOeQ <= sclOeD;
            sdaOeQ <= sdaOeD;
        end
    end

    assign sclOut = 1'b0;
    assign sdaOut = 1'b0;
    assign sclOe = sclOeQ;
    assign sdaOe = sdaOeQ;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_cmd_take: assert property (
        cmdWr && enQ && stateQ == i2cm_pkg::ST_IDLE && pwdata[1:0] == 2'h3
        |=> stateQ == i2cm_pkg::ST_START && status[i2cm_pkg::STAT_BUSY])
        else $error("start command not taken");
    a_start_edge: assert property (
        $rose(sdaOeQ) && stateQ == i2cm_pkg::ST_START |-> !sclOeQ)
        else $error("start edge while scl low");
    a_stop_edge: assert property (
        $fell(sdaOeQ) && stateQ == i2cm_pkg::ST_STOP |-> !sclOeQ)
        else $error("stop edge while scl low");
    a_addr_msb: assert property (
        stateQ == i2cm_pkg::ST_SHIFT && addrPhQ && bitQ == 4'h0 && sampleNow
        |-> sdaOeQ == !addrQ[7])
        else $error("address msb wrong");
    a_dir_bit: assert property (
        stateQ == i2cm_pkg::ST_SHIFT && addrPhQ && bitQ == 4'h7 && sampleNow
        |-> sdaOeQ == !addrQ[0])
        else $error("direction bit wrong");
    a_rx_ack: assert property (
        stateQ == i2cm_pkg::ST_SHIFT && !txMode && bitQ == 4'h8 && sampleNow
        |-> sdaOeQ == ackQ)
        else $error("receive ack drive wrong");
    a_nack_err: assert property (
        stateQ == i2cm_pkg::ST_SHIFT && txMode && bitQ == 4'h8 && sampleNow && sdaS
        |=> status[i2cm_pkg::STAT_ERROR] ##1 status[i2cm_pkg::STAT_ERROR])
        else $error("nack did not flag error");
    a_done_irq: assert property (
        done && maskQ |=> rawQ && irq)
        else $error("completion did not raise interrupt");
    a_irq_clear: assert property (
        wr && off == i2cm_pkg::OFF_IRQ_CLEAR && pwdata[0] && !done |=> !rawQ && !irq)
        else $error("clear did not drop flag");
    a_cfg_init: assert property (
        wr && off == i2cm_pkg::OFF_FUNCTION_CONFIG && pwdata[5] && stateQ == i2cm_pkg::ST_IDLE
        |=> enQ && !status[i2cm_pkg::STAT_ERROR])
        else $error("config write did not enable");

    c_hold: cover property (stateQ == i2cm_pkg::ST_SHIFT ##1 stateQ == i2cm_pkg::ST_HOLD);
    c_stop_done: cover property (stateQ == i2cm_pkg::ST_STOP && done);
    c_arb_lost: cover property ($rose(arbQ));
    c_rx_byte: cover property (rxQ && done);
endmodule : i2cm_master

// ==== sim/i2cm_slave_model.sv ====
// behavioural bus slave: acks its address, captures written bytes, sends on reads
`timescale 1ns/1ps
module i2cm_slave_model #(
    parameter logic [6:0] ADDR = 7'h3B,
    parameter logic [7:0] TX_BYTE = 8'hC3
) (
    input wire logic scl,
    input wire logic sda,
    output logic sdaPull,
    output logic [7:0] rxByte
);
    logic [7:0] sh = 8'h00;
    logic [7:0] txB = TX_BYTE;
    logic first = 1'h0;
    logic rdMode = 1'h0;
    int cnt = 0;
    initial sdaPull = 1'h0;
    initial rxByte = 8'h00;
    always @(negedge sda) begin
        if (scl) begin
            cnt = 0;
            first = 1'h1;
            rdMode = 1'h0;
        end
    end
    always @(posedge scl) begin
        sh = {sh[6:0], sda};
        cnt++;
    end
    // sda moves only at scl fall; a read ends once the master withholds its ack
    always @(negedge scl) begin
        if (cnt == 9) begin
            if (sh[0]) rdMode = 1'h0;
            else if (rdMode && !first) txB = ~txB;
            cnt = 0;
            first = 1'h0;
        end
        if (rdMode && !first) sdaPull <= cnt < 8 && !txB[3'(7 - cnt)];
        else sdaPull <= cnt == 8 && (!first || sh[7:1] == ADDR);
        if (cnt == 8 && !first && !rdMode) rxByte <= sh;
        if (cnt == 8 && first) rdMode = sh[0] && sh[7:1] == ADDR;
    end
endmodule : i2cm_slave_model

// ==== sim/tb_i2cm_master.sv ====
// self-checking bench for the apb bus master
`timescale 1ns/1ps
module tb_i2cm_master;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, irq, sclOut, sclOe, sdaOut, sdaOe, slvPull, err;
    logic [7:0] rxByte;
    int errors = 0;
    int checked = 0;
    realtime t1;
    wire scl = !sclOe;
    wire sda = !(sdaOe | slvPull);
    always #12.5 clk = ~clk;
    i2cm_master #(.DIV_W(8)) i2cm_master_inst (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .sclIn(scl), .sclOut(sclOut),
        .sclOe(sclOe), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe));
    i2cm_slave_model i2cm_slave_model_inst (.scl(scl), .sda(sda), .sdaPull(slvPull),
        .rxByte(rxByte));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'h1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'h1 && n < 50);
        if (pready !== 1'h1) errors++;
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : bus
    task automatic wr(input logic [7:0] o, input logic [31:0] d);
        bus(1'h1, i2cm_pkg::MASTER_BASE | {24'h0, o}, d);
    endtask : wr
    task automatic rx(input logic [7:0] o);
        bus(1'h0, i2cm_pkg::MASTER_BASE | {24'h0, o}, 32'h0);
    endtask : rx
    // start detection lags the command, so bus busy is polled only later
    task automatic idle_wait();
        int n;
        n = 0;
        repeat (100) @(posedge clk);
        do begin
            rx(8'h04);
            n++;
        end while (rd[6] !== 1'h0 && n < 2000);
        chk({31'h0, rd[6]}, 32'h0);
        repeat (20) @(posedge clk);
    endtask : idle_wait
    task automatic t_reset();
        for (int i = 0; i < 9; i++) begin
            rx(8'(i * 4));
            if (i != 1) chk(rd, (i == 3) ? 32'h1 : 32'h0);
        end
        bus(1'h0, i2cm_pkg::SLAVE_BASE, 32'h0);
        chk({31'h0, err}, 32'h1);
    endtask : t_reset
    task automatic t_send();
        wr(8'h20, 32'h20);
        wr(8'h0C, 32'h1);
        wr(8'h00, 32'h76);
        wr(8'h08, 32'hA5);
        wr(8'h10, 32'h1);
        wr(8'h04, 32'h7);
        @(posedge scl);
        @(posedge scl);
        t1 = $realtime;
        @(posedge scl);
        chk(32'($rtoi(($realtime - t1) / 25.0)), 32'h28);
        idle_wait();
        chk({31'h0, irq}, 32'h1);
        chk({24'h0, rxByte}, 32'hA5);
        rx(8'h04);
        chk(rd & 32'h7F, 32'h20);
        rx(8'h18);
        chk(rd, 32'h1);
        wr(8'h1C, 32'h1);
        rx(8'h14);
        chk(rd, 32'h0);
        chk({31'h0, irq}, 32'h0);
    endtask : t_send
    task automatic t_nack();
        wr(8'h10, 32'h0);
        wr(8'h00, 32'hA0);
        wr(8'h04, 32'h7);
        idle_wait();
        rx(8'h04);
        chk(rd & 32'h7F, 32'h26);
        rx(8'h14);
        chk(rd, 32'h1);
        chk({31'h0, irq}, 32'h0);
    endtask : t_nack
    // wait for the completion flag, then clear it for the next command
    task automatic done_wait();
        int n;
        n = 0;
        do begin
            rx(8'h14);
            n++;
        end while (rd[0] !== 1'h1 && n < 2000);
        chk(rd, 32'h1);
        wr(8'h1C, 32'h1);
    endtask : done_wait
    task automatic t_recv();
        wr(8'h1C, 32'h1);
        wr(8'h00, 32'h77);
        wr(8'h04, 32'hB);
        done_wait();
        rx(8'h04);
        chk(rd & 32'h7F, 32'h40);
        rx(8'h08);
        chk(rd, 32'hC3);
        wr(8'h04, 32'h5);
        idle_wait();
        rx(8'h08);
        chk(rd, 32'h3C);
        rx(8'h04);
        chk(rd & 32'h7F, 32'h20);
    endtask : t_recv
    task automatic give_verdict();
        if (errors == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'h1;
        t_reset();
        t_send();
        t_nack();
        t_recv();
        give_verdict();
    end
    initial begin
        #2000000;
        errors++;
        give_verdict();
    end
endmodule : tb_i2cm_master
